// *** ccr_pkg.sv ***
package ccr_pkg;

   // Control port word layout.
   localparam int unsigned ADDR_W = 7;
   localparam int unsigned DATA_W = 9;
   localparam logic [3:0]  BYTE_BITS = 4'h8;

   // Register offsets.
   localparam logic [6:0] REG_SAMPLING_CONTROL = 7'h08;
   localparam logic [6:0] REG_SOFTWARE_RESET   = 7'h0F;

   // Sampling control field positions.
   localparam int unsigned CORE_HALVE_POS      = 6;
   localparam int unsigned CLOCK_OUT_HALVE_POS = 7;

   // Reset values and the reset trigger word.
   localparam logic [8:0] SAMPLING_CONTROL_RST = 9'h000;
   localparam logic [8:0] SOFTWARE_RESET_WORD  = 9'h000;
   localparam logic       POR_RST              = 1'h1;
   localparam logic       DEV_RST_RST          = 1'h1;
   localparam logic [2:0] SELECT_IDLE_RST      = 3'h7;

   // The value is arbitrary.
   localparam logic [6:0] DEVICE_ADDR_DFLT = 7'h2C;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } ccr_word_s;

   typedef enum logic [2:0] {
      TW_IDLE,
      TW_DEVADR,
      TW_ACK_DEV,
      TW_BYTE_HI,
      TW_ACK_HI,
      TW_BYTE_LO,
      TW_ACK_LO
   } ccr_twowire_e;

   typedef struct packed {
      logic [1:0]   mode_sync;
      logic [2:0]   sclk_sync;
      logic [2:0]   sdin_sync;
      logic [2:0]   csb_sync;
      logic [15:0]  shift;
      logic [3:0]   bit_cnt;
      ccr_twowire_e tw;
      logic         wr_valid;
      ccr_word_s    wr_word;
      logic         sw_rst;
      logic         sda_oe;
   } ccr_port_state_s;

   typedef struct packed {
      logic [2:0] ref_sync;
      logic [1:0] ok_sync;
      logic [1:0] low_sync;
      logic       por;
      logic       dev_rst;
      logic [8:0] samp;
      logic       core_clk;
      logic       clk_out;
   } ccr_core_state_s;

   function automatic logic ccr_is_reset_write(input ccr_word_s w);
      return (w.addr == REG_SOFTWARE_RESET) && (w.data == SOFTWARE_RESET_WORD);
   endfunction

endpackage

// *** ccr_ctrl_port.sv ***
module ccr_ctrl_port import ccr_pkg::*; #(
   parameter logic [6:0] DEVICE_ADDR = DEVICE_ADDR_DFLT
) (
   // Clock and reset
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   // Control port pins
   input  wire logic      two_wire_i,
   input  wire logic      sclk_i,
   input  wire logic      sdin_i,
   input  wire logic      select_i,
   output logic           sda_o,
   output logic           sda_oe_o,
   // Decoded writes
   output logic           wr_valid_o,
   output ccr_word_s      wr_word_o,
   output logic           sw_rst_o
);

   ccr_port_state_s q;
   ccr_port_state_s d;

   logic two_wire;
   logic sclk_rise;
   logic sclk_fall;
   logic sel_rise;
   logic sda_rise;
   logic sda_fall;

   assign two_wire  = q.mode_sync[1];
   assign sclk_rise = q.sclk_sync[1] & ~q.sclk_sync[2];
   assign sclk_fall = ~q.sclk_sync[1] & q.sclk_sync[2];
   assign sel_rise  = q.csb_sync[1] & ~q.csb_sync[2];
   assign sda_rise  = q.sdin_sync[1] & ~q.sdin_sync[2];
   assign sda_fall  = ~q.sdin_sync[1] & q.sdin_sync[2];

   always_comb begin
      d = q;
      d.wr_valid  = 1'b0;
      d.mode_sync = {q.mode_sync[0], two_wire_i};
      d.sclk_sync = {q.sclk_sync[1:0], sclk_i};
      d.sdin_sync = {q.sdin_sync[1:0], sdin_i};
      d.csb_sync  = {q.csb_sync[1:0], select_i};
      if (!two_wire) begin
         d.tw     = TW_IDLE;
         d.sda_oe = 1'b0;
         // (RL7) Release on serial clock.
         if (q.sw_rst && sclk_rise) begin
            d.sw_rst = 1'b0;
         end
         if (!q.csb_sync[1] && sclk_rise) begin
            d.shift = {q.shift[14:0], q.sdin_sync[1]};
         end
         // (RL7) Assert on select rise; this set wins over the release above.
         if (sel_rise) begin
            d.wr_valid = 1'b1;
            d.wr_word  = ccr_word_s'(q.shift);
            if (ccr_is_reset_write(ccr_word_s'(q.shift))) begin
               d.sw_rst = 1'b1;
            end
         end
      end else begin
         case (q.tw)
            TW_DEVADR, TW_BYTE_HI, TW_BYTE_LO: begin
               if (sclk_rise) begin
                  d.shift   = {q.shift[14:0], q.sdin_sync[1]};
                  d.bit_cnt = 4'(q.bit_cnt + 4'h1);
               end
               if (sclk_fall && q.bit_cnt == BYTE_BITS) begin
                  d.bit_cnt = 4'h0;
                  d.sda_oe  = 1'b1;
                  if (q.tw == TW_DEVADR) begin
                     if (q.shift[7:0] == {DEVICE_ADDR, 1'b0}) begin
                        d.tw = TW_ACK_DEV;
                     end else begin
                        d.tw     = TW_IDLE;
                        d.sda_oe = 1'b0;
                     end
                  end else if (q.tw == TW_BYTE_HI) begin
                     d.tw = TW_ACK_HI;
                  end else begin
                     d.tw       = TW_ACK_LO;
                     d.wr_valid = 1'b1;
                     d.wr_word  = ccr_word_s'(q.shift);
                     // (RL8) Hold reset through acknowledge.
                     d.sw_rst   = ccr_is_reset_write(ccr_word_s'(q.shift));
                  end
               end
            end
            TW_ACK_DEV, TW_ACK_HI, TW_ACK_LO: begin
               if (sclk_fall) begin
                  d.sda_oe = 1'b0;
                  d.sw_rst = 1'b0;
                  if (q.tw == TW_ACK_DEV) begin
                     d.tw = TW_BYTE_HI;
                  end else if (q.tw == TW_ACK_HI) begin
                     d.tw = TW_BYTE_LO;
                  end else begin
                     d.tw = TW_IDLE;
                  end
               end
            end
            TW_IDLE: begin
               d.bit_cnt = 4'h0;
            end
            default: begin
               d.tw = TW_IDLE;
            end
         endcase
         // Start and stop conditions override any byte in progress.
         if (q.sclk_sync[1] && (sda_fall || sda_rise)) begin
            d.tw      = sda_fall ? TW_DEVADR : TW_IDLE;
            d.bit_cnt = 4'h0;
            d.sda_oe  = 1'b0;
            d.sw_rst  = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // The select line idles high; a zero here would fake a select rise.
         q          <= '0;
         q.csb_sync <= SELECT_IDLE_RST;
      end else begin
         q <= d;
      end
   end

   // The data line is only ever pulled low; the pad resolves the level.
   assign sda_o      = 1'b0;
   assign sda_oe_o   = q.sda_oe;
   assign wr_valid_o = q.wr_valid;
   assign wr_word_o  = q.wr_word;
   assign sw_rst_o   = q.sw_rst;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_three_wire_set;
      !two_wire && !$past(two_wire) && sel_rise && ccr_is_reset_write(ccr_word_s'(q.shift))
         |=> q.sw_rst;
   endproperty
   a_three_wire_set: assert property (p_three_wire_set) // (RL7)
      else $error("Software reset not asserted on select rise.");

   property p_three_wire_hold;
      !two_wire && !$past(two_wire) && q.sw_rst && !sclk_rise |=> q.sw_rst;
   endproperty
   a_three_wire_hold: assert property (p_three_wire_hold) // (RL7)
      else $error("Software reset released before a serial clock rise.");

   property p_two_wire_ack;
      two_wire && $past(two_wire) && q.sw_rst |-> (q.tw == TW_ACK_LO) && q.sda_oe;
   endproperty
   a_two_wire_ack: assert property (p_two_wire_ack) // (RL8)
      else $error("Software reset active outside the final acknowledge.");

   c_two_wire_reset: cover property (two_wire && $rose(q.sw_rst));
   c_three_wire_reset: cover property (!two_wire && $rose(q.sw_rst));

endmodule

// *** ccr_clock_reset.sv ***
// Summary of operation
// (RL1) Core clock equals reference clock, or reference halved when core halve bit set.
// (RL2) Buffered clock output copies core clock, or halves it when its bit set.
// (RL3) Halved buffered output changes only on reference clock rising edges.
// (RL4) Reference, core and output clocks keep one polarity, only delay between them.
// (RL5) Buffered clock output is held low while the device is in reset.
// (RL6) Writing zero to the software reset register restores all defaults.
// (RL7) Three-wire reset sets on select rise, clears on next serial clock rise.
// (RL8) Two-wire reset lasts through the acknowledge of the reset write.
// (RL9) Power-on reset holds state until core supply passes its release threshold.
// (RL10) Supply dropping below lower threshold reasserts power-on reset, with hysteresis.
// (RL11) Halving lets a 512fs reference drive a core timed at 256fs.
// (RL12) External reference clock works with no register setup at all.
// (RL13) Software should prefer the halved output rate to save power.
// (RL14) Both divider select bits clear on power-on and software reset.
module ccr_clock_reset import ccr_pkg::*; #(
   parameter logic [6:0] DEVICE_ADDR = DEVICE_ADDR_DFLT
) (
   // Clock and reset
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   // Reference clock pin
   input  wire logic      reference_clock_input_i,
   // Core supply monitor comparators
   input  wire logic      core_supply_ok_i,
   input  wire logic      core_supply_low_i,
   // Control port pins
   input  wire logic      ctrl_two_wire_i,
   input  wire logic      ctrl_sclk_i,
   input  wire logic      ctrl_sdin_i,
   input  wire logic      control_select_line_i,
   output logic           ctrl_sda_o,
   output logic           ctrl_sda_oe_o,
   // Derived clocks
   output logic           core_clock_o,
   output logic           buffered_clock_output_o,
   // Status
   output logic           device_reset_o,
   output logic [8:0]     sampling_control_o
);

   ccr_core_state_s q;
   ccr_core_state_s d;

   logic      wr_valid;
   ccr_word_s wr_word;
   logic      sw_rst;
   logic      ref_rise;
   logic      core_halve;
   logic      clock_out_halve;
   logic      reset_now;
   logic      core_rise;

   ccr_ctrl_port #(
      .DEVICE_ADDR (DEVICE_ADDR)
   ) u_port (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .two_wire_i  (ctrl_two_wire_i),
      .sclk_i      (ctrl_sclk_i),
      .sdin_i      (ctrl_sdin_i),
      .select_i    (control_select_line_i),
      .sda_o       (ctrl_sda_o),
      .sda_oe_o    (ctrl_sda_oe_o),
      .wr_valid_o  (wr_valid),
      .wr_word_o   (wr_word),
      .sw_rst_o    (sw_rst)
   );

   // The reference is sampled, so it must stay below half the system clock rate.
   assign ref_rise        = q.ref_sync[1] & ~q.ref_sync[2];
   assign core_halve      = q.samp[CORE_HALVE_POS];
   assign clock_out_halve = q.samp[CLOCK_OUT_HALVE_POS];
   assign reset_now       = q.por | sw_rst;

   always_comb begin
      d = q;
      d.ref_sync = {q.ref_sync[1:0], reference_clock_input_i};
      d.ok_sync  = {q.ok_sync[0], core_supply_ok_i};
      d.low_sync = {q.low_sync[0], core_supply_low_i};

      // (RL10) Low supply reasserts reset.
      if (q.low_sync[1]) begin
         d.por = 1'b1;
      // (RL9) Release past upper threshold.
      end else if (q.ok_sync[1]) begin
         d.por = 1'b0;
      end
      d.dev_rst = reset_now;

      if (wr_valid && wr_word.addr == REG_SAMPLING_CONTROL) begin
         d.samp = wr_word.data;
      end
      // (RL6) Reset restores defaults.
      // (RL14) Divider bits clear.
      if (reset_now) begin
         d.samp = SAMPLING_CONTROL_RST;
      end

      // (RL1) Core clock source select.
      // (RL12) Direct path by default.
      // (RL11) Halve on reference rises.
      if (!core_halve) begin
         d.core_clk = q.ref_sync[1];
      end else if (ref_rise) begin
         d.core_clk = ~q.core_clk;
      end
      core_rise = d.core_clk & ~q.core_clk;

      // (RL2) Output copy or halve.
      // (RL3) Toggle only on rising edges.
      // (RL4) No inversion in path.
      if (!clock_out_halve) begin
         d.clk_out = d.core_clk;
      // A core rise made by a divider switch is no reference rise, so it is skipped.
      end else if (core_rise && ref_rise) begin
         d.clk_out = ~q.clk_out;
      end
      // (RL5) Output low in reset.
      if (reset_now) begin
         d.clk_out = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q         <= '0;
         q.por     <= POR_RST;
         q.dev_rst <= DEV_RST_RST;
      end else begin
         q <= d;
      end
   end

   // Both clocks leave the same flip-flop stage, so they stay aligned to the cycle.
   assign core_clock_o            = q.core_clk;
   assign buffered_clock_output_o = q.clk_out;
   assign device_reset_o          = q.dev_rst;
   assign sampling_control_o      = q.samp;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_core_direct;
      !core_halve && !$past(core_halve) |-> q.core_clk == $past(q.ref_sync[1]);
   endproperty
   a_core_direct: assert property (p_core_direct) // (RL1)
      else $error("Undivided core clock does not follow the reference.");

   property p_core_halved;
      core_halve && $past(core_halve) && $past(ref_rise) |-> q.core_clk != $past(q.core_clk);
   endproperty
   a_core_halved: assert property (p_core_halved) // (RL1)
      else $error("Halved core clock missed a reference rise.");

   property p_core_rate;
      core_halve && $past(core_halve) && !$past(ref_rise) |-> $stable(q.core_clk);
   endproperty
   a_core_rate: assert property (p_core_rate) // (RL11)
      else $error("Halved core clock moved without a reference rise.");

   property p_out_copy;
      !$past(clock_out_halve) && !$past(reset_now) |-> q.clk_out == q.core_clk;
   endproperty
   a_out_copy: assert property (p_out_copy) // (RL2)
      else $error("Buffered output differs from the core clock.");

   property p_out_halved;
      !$past(reset_now) && $past(clock_out_halve) && $past(core_rise) && $past(ref_rise)
         |-> q.clk_out != $past(q.clk_out);
   endproperty
   a_out_halved: assert property (p_out_halved) // (RL2)
      else $error("Halved buffered output missed a core clock rise.");

   property p_out_edge;
      $past(clock_out_halve) && !$past(reset_now) && $changed(q.clk_out) |-> $past(ref_rise);
   endproperty
   a_out_edge: assert property (p_out_edge) // (RL3)
      else $error("Halved buffered output changed off a reference rise.");

   property p_polarity;
      $rose(q.clk_out) |-> $past(q.ref_sync[1]) && q.core_clk;
   endproperty
   a_polarity: assert property (p_polarity) // (RL4)
      else $error("Buffered output rose while the reference was low.");

   property p_reset_low;
      reset_now |=> !q.clk_out;
   endproperty
   a_reset_low: assert property (p_reset_low) // (RL5)
      else $error("Buffered output not low during reset.");

   property p_sw_defaults;
      sw_rst |=> q.samp == SAMPLING_CONTROL_RST && q.dev_rst;
   endproperty
   a_sw_defaults: assert property (p_sw_defaults) // (RL6)
      else $error("Software reset did not restore defaults.");

   property p_div_clear;
      q.por |=> !q.samp[CORE_HALVE_POS] && !q.samp[CLOCK_OUT_HALVE_POS];
   endproperty
   a_div_clear: assert property (p_div_clear) // (RL14)
      else $error("Divider select bits survived power-on reset.");

   property p_por_release;
      q.ok_sync[1] && !q.low_sync[1] |=> !q.por ##1 (!q.dev_rst || $past(sw_rst));
   endproperty
   a_por_release: assert property (p_por_release) // (RL9)
      else $error("Power-on reset not released above threshold.");

   property p_por_reassert;
      q.low_sync[1] |=> q.por ##1 q.dev_rst;
   endproperty
   a_por_reassert: assert property (p_por_reassert) // (RL10)
      else $error("Power-on reset not reasserted on low supply.");

   property p_hysteresis;
      !q.ok_sync[1] && !q.low_sync[1] |=> q.por == $past(q.por);
   endproperty
   a_hysteresis: assert property (p_hysteresis) // (RL10)
      else $error("Power-on reset moved between thresholds.");

   property p_write_lands;
      wr_valid && wr_word.addr == REG_SAMPLING_CONTROL && !reset_now
         |=> q.samp == $past(wr_word.data);
   endproperty
   a_write_lands: assert property (p_write_lands) // (RL1)
      else $error("Sampling control write did not land.");

   property p_samp_hold;
      !wr_valid && !reset_now |=> $stable(q.samp);
   endproperty
   a_samp_hold: assert property (p_samp_hold) // (RL2)
      else $error("Sampling control changed without a write.");

   c_core_halved: cover property (core_halve && $rose(q.core_clk) ##[1:20] $rose(q.core_clk));
   c_out_halved: cover property (clock_out_halve && $rose(q.clk_out));
   c_sw_reset: cover property ($rose(sw_rst) ##1 q.dev_rst);
   c_por_cycle: cover property ($fell(q.por) ##[1:200] $rose(q.por));

endmodule

// *** ccr_host_model.sv ***
module ccr_host_model import ccr_pkg::*; (
   // Clock and device answers
   input  wire logic clk_i,
   input  wire logic sda_oe_i,
   input  wire logic dev_rst_i,
   // Control port and reference clock pins
   output logic      two_wire_o,
   output logic      sclk_o,
   output logic      sdin_o,
   output logic      select_o,
   output logic      ref_clk_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int H = 6;
   logic        sda_q;
   logic [2:0]  ref_cnt_q;
   logic [15:0] word_q;
   // Pulled-up data line; the device pulling low wins in two-wire mode.
   assign sdin_o = two_wire_o ? (sda_q & ~sda_oe_i) : sda_q;
   initial begin
      two_wire_o = 1'b0;
      sclk_o     = 1'b0;
      select_o   = 1'b1;
      sda_q      = 1'b1;
      ref_clk_o  = 1'b0;
      ref_cnt_q  = 3'h0;
   end
   always @(posedge clk_i) begin
      ref_cnt_q <= ref_cnt_q + 3'h1;
      if (ref_cnt_q == 3'h7) begin
         ref_clk_o <= ~ref_clk_o;
      end
   end
   task automatic gap();
      repeat (H) @(posedge clk_i);
   endtask
   task automatic pulse();
      sclk_o <= 1'b1;
      gap();
      sclk_o <= 1'b0;
      gap();
   endtask
   task automatic bit_out(input logic b);
      sda_q <= b;
      gap();
      pulse();
   endtask
   task automatic set_mode(input logic two);
      @(posedge clk_i);
      two_wire_o <= two;
      sclk_o     <= two;
      sda_q      <= 1'b1;
      repeat (4) gap();
   endtask
   task automatic write3(input logic [6:0] a, input logic [8:0] d);
      @(posedge clk_i);
      word_q = {a, d};
      select_o <= 1'b0;
      gap();
      for (int i = 15; i >= 0; i--) begin
         bit_out(word_q[i]);
      end
      select_o <= 1'b1;
      // A released line must not keep showing the last bit.
      sda_q <= ~word_q[0];
      gap();
   endtask
   task automatic reset3();
      write3(REG_SOFTWARE_RESET, SOFTWARE_RESET_WORD);
   endtask
   task automatic ack_bit(output logic ack, output logic rst_seen);
      sda_q <= 1'b1;
      gap();
      sclk_o <= 1'b1;
      gap();
      ack = ~sdin_o;
      rst_seen = dev_rst_i;
      sclk_o <= 1'b0;
      gap();
   endtask
   task automatic write2(input logic [6:0] dev, input logic [6:0] a,
                         input logic [8:0] d, output logic [2:0] acks,
                         output logic rst_seen);
      logic [23:0] f;
      logic        a_bit;
      @(posedge clk_i);
      f = {dev, 1'b0, a, d};
      sda_q <= 1'b0;
      gap();
      sclk_o <= 1'b0;
      gap();
      for (int i = 23; i >= 0; i--) begin
         bit_out(f[i]);
         if (i % 8 == 0) begin
            ack_bit(a_bit, rst_seen);
            acks[i / 8] = a_bit;
         end
      end
      sda_q <= 1'b0;
      gap();
      sclk_o <= 1'b1;
      gap();
      sda_q <= 1'b1;
      gap();
   endtask
endmodule

// *** codec_clock_reset_control_tb.sv ***
module codec_clock_reset_control_tb import ccr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [8:0]  ROW_D [5] = '{9'h000, 9'h040, 9'h080, 9'h0C0, 9'h1BF};
   localparam logic [15:0] ROW_C [5] = '{16'h10, 16'h20, 16'h10, 16'h20, 16'h10};
   localparam logic [15:0] ROW_O [5] = '{16'h10, 16'h20, 16'h20, 16'h40, 16'h20};
   logic        clk, rst, supply_ok, supply_low, mon3, prev_buf, rs;
   logic        two_wire, sclk, sdin, sel, ref_clk, sda, sda_oe;
   logic        core_clk, buf_clk, dev_rst;
   logic [8:0]  samp;
   logic [2:0]  acks;
   logic [15:0] n, diff, bad3, seen3;
   int          mismatches, checks;

   ccr_clock_reset dut_u (
      .clk_i                   (clk),
      .rst_i                   (rst),
      .reference_clock_input_i (ref_clk),
      .core_supply_ok_i        (supply_ok),
      .core_supply_low_i       (supply_low),
      .ctrl_two_wire_i         (two_wire),
      .ctrl_sclk_i             (sclk),
      .ctrl_sdin_i             (sdin),
      .control_select_line_i   (sel),
      .ctrl_sda_o              (sda),
      .ctrl_sda_oe_o           (sda_oe),
      .core_clock_o            (core_clk),
      .buffered_clock_output_o (buf_clk),
      .device_reset_o          (dev_rst),
      .sampling_control_o      (samp)
   );
   ccr_host_model host_u (
      .clk_i      (clk),
      .sda_oe_i   (sda_oe),
      .dev_rst_i  (dev_rst),
      .two_wire_o (two_wire),
      .sclk_o     (sclk),
      .sdin_o     (sdin),
      .select_o   (sel),
      .ref_clk_o  (ref_clk)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Halved output may only move while the core clock is high, just after its rise.
   always @(negedge clk) begin
      prev_buf <= buf_clk;
      if (mon3 === 1'b1 && samp[7] === 1'b1 && buf_clk !== prev_buf) begin
         seen3 <= seen3 + 16'h1;
         if (core_clk !== 1'b1) begin
            bad3 <= bad3 + 16'h1;
         end
      end
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic expect_rst(input string what, input logic v);
      @(negedge clk);
      for (int k = 0; k < 12 && dev_rst !== v; k++) @(negedge clk);
      check(what, dev_rst, v);
   endtask
   function automatic logic pick(input logic o);
      return o ? buf_clk : core_clk;
   endfunction
   task automatic period(input logic o, output logic [15:0] p);
      for (int k = 0; k < 200 && pick(o) !== 1'b0; k++) @(negedge clk);
      for (int k = 0; k < 200 && pick(o) !== 1'b1; k++) @(negedge clk);
      @(negedge clk);
      p = 16'h1;
      while (pick(o) !== 1'b0 && p < 16'hFF) begin
         @(negedge clk);
         p++;
      end
      while (pick(o) !== 1'b1 && p < 16'hFF) begin
         @(negedge clk);
         p++;
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      supply_ok = 1'b0;
      supply_low = 1'b1;
      mon3 = 1'b0;
      bad3 = 16'h0;
      seen3 = 16'h0;
      repeat (7) @(posedge clk);
      @(negedge clk);
      check("reset dev_rst", dev_rst, 1'b1);
      check("reset clk out", buf_clk, 1'b0);
      check("reset samp", samp, SAMPLING_CONTROL_RST);
      @(posedge clk);
      rst <= 1'b0;
      repeat (20) @(negedge clk);
      check("por held", dev_rst, 1'b1);
      check("por clk out", buf_clk, 1'b0);
      @(posedge clk);
      supply_ok <= 1'b1;
      supply_low <= 1'b0;
      expect_rst("por release", 1'b0);
      @(posedge clk);
      supply_ok <= 1'b0;
      repeat (12) @(negedge clk);
      check("between thresholds", dev_rst, 1'b0);
      @(posedge clk);
      supply_low <= 1'b1;
      expect_rst("supply drop", 1'b1);
      @(posedge clk);
      supply_low <= 1'b0;
      repeat (12) @(negedge clk);
      check("between thresholds", dev_rst, 1'b1);
      @(posedge clk);
      supply_ok <= 1'b1;
      expect_rst("por release", 1'b0);
      period(1'b0, n);
      check("core period", n, 16'h10);
      period(1'b1, n);
      check("out period", n, 16'h10);
      $display("test supply done");
      for (int r = 0; r < 5; r++) begin
         host_u.write3(REG_SAMPLING_CONTROL, ROW_D[r]);
         @(negedge clk);
         check("samp", samp, ROW_D[r]);
         mon3 = 1'b1;
         period(1'b0, n);
         check("core period", n, ROW_C[r]);
         period(1'b1, n);
         check("out period", n, ROW_O[r]);
         mon3 = 1'b0;
         diff = 16'h0;
         repeat (32) begin
            @(negedge clk);
            diff = diff + 16'(buf_clk !== core_clk);
         end
         if (!ROW_D[r][7]) check("out copy", diff, 16'h0);
      end
      check("out off edge", bad3, 16'h0);
      check("out toggles", 16'(seen3 != 16'h0), 16'h1);
      $display("test dividers done");
      host_u.write3(REG_SOFTWARE_RESET, 9'h001);
      repeat (12) @(negedge clk);
      check("nonzero reset word", dev_rst, 1'b0);
      check("samp kept", samp, 9'h1BF);
      host_u.reset3();
      expect_rst("sw reset", 1'b1);
      check("samp cleared", samp, SAMPLING_CONTROL_RST);
      repeat (20) @(negedge clk);
      check("reset held", dev_rst, 1'b1);
      check("reset clk out", buf_clk, 1'b0);
      @(posedge clk);
      host_u.pulse();
      expect_rst("sw release", 1'b0);
      $display("test three wire reset done");
      host_u.set_mode(1'b1);
      host_u.write2(DEVICE_ADDR_DFLT, REG_SAMPLING_CONTROL, 9'h0C0, acks, rs);
      @(negedge clk);
      check("acks", acks, 3'h7);
      check("sda value", sda, 1'b0);
      check("samp two wire", samp, 9'h0C0);
      host_u.write2(DEVICE_ADDR_DFLT ^ 7'h01, REG_SAMPLING_CONTROL, 9'h040, acks, rs);
      @(negedge clk);
      check("acks other device", acks, 3'h0);
      check("samp kept", samp, 9'h0C0);
      host_u.write2(DEVICE_ADDR_DFLT, REG_SOFTWARE_RESET, SOFTWARE_RESET_WORD, acks, rs);
      @(negedge clk);
      check("reset during ack", rs, 1'b1);
      check("reset after ack", dev_rst, 1'b0);
      check("samp cleared", samp, SAMPLING_CONTROL_RST);
      $display("test two wire done");
      give_verdict();
   end
endmodule
